// >>> logic/pco_map.svh
/*
 * Register offsets, field positions, reset values and timing counts for
 * the PWM channel output configuration block.
 * Assumes a 32-bit APB with byte addresses on word boundaries.
 */
`ifndef PCO_MAP_SVH
`define PCO_MAP_SVH

`define PCO_ADDR_W          8
`define PCO_OFS_CHB_CFG     8'h00
`define PCO_OFS_CHC_CFG     8'h04
`define PCO_OFS_GAP_TIME    8'h08
`define PCO_OFS_STATUS      8'h0C

`define PCO_KEY_MSB         31
`define PCO_KEY_LSB         24
`define PCO_KEY_VALUE       8'h5A

`define PCO_CFG_W           19
`define PCO_CFG_RSV_BIT     15
`define PCO_CFG_RESET       19'h00000

`define PCO_GAP_FALL_MSB    15
`define PCO_GAP_FALL_LSB    8
`define PCO_GAP_RISE_MSB    7
`define PCO_GAP_RISE_LSB    0
`define PCO_GAP_RESET       8'h00

`define PCO_STAT_LVL_LSB    0
`define PCO_STAT_OE_LSB     4
`define PCO_STAT_FAULT_LSB  8
`define PCO_STAT_OVL_LSB    10

`define PCO_TICK_CYCLES     1

`endif

// >>> logic/pco_pkg.sv
/*
 * Types of the PWM channel output configuration block.
 * Field order of the config struct follows the register bit order.
 */
`default_nettype none

package pco_pkg;

    typedef enum logic [1:0] {
        PCO_ACT_HIZ  = 2'h0,
        PCO_ACT_LOW  = 2'h1,
        PCO_ACT_HIGH = 2'h2,
        PCO_ACT_NONE = 2'h3
    } pco_act_e;

    typedef enum logic [1:0] {
        PCO_OVL_GLOBAL_LATCHED = 2'h0,
        PCO_OVL_GLOBAL         = 2'h1,
        PCO_OVL_CHAN_LATCHED   = 2'h2,
        PCO_OVL_CHAN_DIRECT    = 2'h3
    } pco_ovl_mode_e;

    // Bits 18..0 of a channel configuration register
    typedef struct packed {
        logic          fault_source_select;
        pco_ovl_mode_e overcurrent_source_mode;
        logic          reserved;
        logic          pos_invert;
        logic          neg_invert;
        logic          pos_fall_gap_en;
        logic          pos_rise_gap_en;
        logic          neg_fall_gap_en;
        logic          neg_rise_gap_en;
        logic          bit8_ovl;
        pco_act_e      pos_fault_action;
        pco_act_e      neg_fault_action;
        pco_act_e      pos_overcurrent_action;
        pco_act_e      neg_overcurrent_action;
    } pco_cfg_s;

    // Fault halt and global overcurrent inputs shared by both channels
    typedef struct packed {
        logic latched_fault_halt;
        logic direct_fault_halt;
        logic global_latched_overcurrent;
        logic global_overcurrent;
    } pco_glob_s;

    // Per-channel overcurrent inputs
    typedef struct packed {
        logic latched_overcurrent;
        logic overcurrent_pin;
    } pco_chan_in_s;

    typedef struct packed {
        logic [7:0] fall;
        logic [7:0] rise;
    } pco_gap_s;

endpackage

`default_nettype wire

// >>> logic/pco_top.sv
/*
 * Output configuration of PWM channels B and C: key-protected config
 * registers, fault and overcurrent source selection, polarity, per-edge
 * dead-time gaps and forced output states, behind an APB slave.
 * Assumes all inputs are synchronous to pclk; the pad turns a low enable
 * into high impedance.
 */
// Decided for this implementation: the register addresses and the APB slave port.
//
// Functional notes
// - Config writes change contents only when the top byte holds the key.
// - Fault source select: 0 latched fault halt, 1 direct fault halt.
// - Channel B overcurrent mode: global latched, global, B latched, B pin.
// - Channel C overcurrent mode: global latched, global, C latched, C pin.
// - B positive output follows PWM B, inverted when its invert bit set.
// - B negative output is inverse of PWM B, true when invert bit set.
// - B positive output falling and rising gap enables delay its edges.
// - B negative output falling and rising gap enables delay its edges.
// - Channel C has the same invert and gap enable bits as B.
// - B input select: 0 global overcurrent, 1 dedicated B pin.
// - C bit 8 sets the C pin polarity; 0 means active high.
// - Fault action of B positive: hi-z, low, high or none.
// - Fault action of B negative uses the same coding.
// - Overcurrent action of B positive: hi-z, low, high or none.
// - Overcurrent action of B negative: hi-z, low, high or none.
// - Forced states appear at once, without period wait or gap.
// - Channel B has two outputs and two dedicated overcurrent inputs, B latched and B pin.
// - Channel C applies fault and overcurrent action fields at bits 7..0.
// - Each gap equals its eight-bit count times the gap tick period.
`timescale 1ns/1ps
`default_nettype none
`include "pco_map.svh"

module pco_top
    import pco_pkg::*;
#(
    parameter int unsigned GAP_TICK_CYCLES = `PCO_TICK_CYCLES
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`PCO_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   chb_pwm,
    input  wire logic                   chc_pwm,
    input  wire pco_glob_s              glob_in,
    input  wire pco_chan_in_s           chb_in,
    input  wire pco_chan_in_s           chc_in,
    output var  logic [3:0]             drive_level,
    output var  logic [3:0]             drive_enable
);

    localparam int unsigned TICK_W = $clog2(GAP_TICK_CYCLES + 1);
    localparam int unsigned CNT_W  = 8 + TICK_W;

    // The gap counter width is sized for this range only
    if (GAP_TICK_CYCLES < 1 || GAP_TICK_CYCLES > 65535) begin : g_bad_tick
        $error("GAP_TICK_CYCLES out of range");
    end

    // Output index: 0 B positive, 1 B negative, 2 C positive, 3 C negative
    pco_cfg_s            chb_cfg_q;
    pco_cfg_s            chc_cfg_q;
    pco_gap_s            gap_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [3:0]          level_q;
    logic [3:0]          enable_q;
    logic [3:0]          shown_q;
    logic [CNT_W-1:0]    gap_cnt_q [4];
    logic [3:0]          target;
    logic [1:0]          fault_cond;
    logic [1:0]          ovl_cond;
    logic                wr_take;
    logic                key_ok;
    logic                addr_ok;
    pco_cfg_s            cfg_wr;

    function automatic logic [1:0] act_drive(input pco_act_e act, input logic normal);
        // Returns {enable, level}
        unique case (act)
            PCO_ACT_HIZ:  act_drive = 2'h0;
            PCO_ACT_LOW:  act_drive = 2'h2;
            PCO_ACT_HIGH: act_drive = 2'h3;
            PCO_ACT_NONE: act_drive = {1'b1, normal};
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] gap_need(input logic [7:0] count, input logic en);
        logic [CNT_W+15:0] prod;
        prod = (CNT_W + 16)'(count) * (CNT_W + 16)'(GAP_TICK_CYCLES);
        gap_need = en ? prod[CNT_W-1:0] : '0;
    endfunction

    function automatic logic fault_pick(input pco_cfg_s cfg);
        fault_pick = cfg.fault_source_select ? glob_in.direct_fault_halt
                                             : glob_in.latched_fault_halt;
    endfunction

    assign key_ok  = (pwdata[`PCO_KEY_MSB:`PCO_KEY_LSB] == `PCO_KEY_VALUE);
    assign addr_ok = (paddr == `PCO_OFS_CHB_CFG) || (paddr == `PCO_OFS_CHC_CFG)
                  || (paddr == `PCO_OFS_GAP_TIME) || (paddr == `PCO_OFS_STATUS);
    assign wr_take = psel & penable & pready_q & pwrite & addr_ok;

    always_comb begin
        cfg_wr          = pco_cfg_s'(pwdata[`PCO_CFG_W-1:0]);
        cfg_wr.reserved = 1'b0;
    end

    // One wait-free access: answer is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & ~penable & ~pready_q;
            pslverr_q <= psel & ~penable & ~pready_q & ~addr_ok;
        end
    end

    // key byte reads back as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel & ~penable & ~pready_q) begin
            prdata_q <= 32'h0000_0000;
            unique case (paddr)
                `PCO_OFS_CHB_CFG:  prdata_q[`PCO_CFG_W-1:0] <= chb_cfg_q;
                `PCO_OFS_CHC_CFG:  prdata_q[`PCO_CFG_W-1:0] <= chc_cfg_q;
                `PCO_OFS_GAP_TIME: prdata_q[15:0] <= gap_q;
                `PCO_OFS_STATUS: begin
                    prdata_q[`PCO_STAT_LVL_LSB +: 4]   <= level_q;
                    prdata_q[`PCO_STAT_OE_LSB +: 4]    <= enable_q;
                    prdata_q[`PCO_STAT_FAULT_LSB +: 2] <= fault_cond;
                    prdata_q[`PCO_STAT_OVL_LSB +: 2]   <= ovl_cond;
                end
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // key check on channel config writes
    // a rejected write leaves every field as it was
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chb_cfg_q <= pco_cfg_s'(`PCO_CFG_RESET);
        end else if (wr_take && key_ok && paddr == `PCO_OFS_CHB_CFG) begin
            chb_cfg_q <= cfg_wr;
        end
    end

    // same key guard for channel C
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chc_cfg_q <= pco_cfg_s'(`PCO_CFG_RESET);
        end else if (wr_take && key_ok && paddr == `PCO_OFS_CHC_CFG) begin
            chc_cfg_q <= cfg_wr;
        end
    end

    // Gap counts are not key protected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q.fall <= `PCO_GAP_RESET;
            gap_q.rise <= `PCO_GAP_RESET;
        end else if (wr_take && paddr == `PCO_OFS_GAP_TIME) begin
            gap_q.fall <= pwdata[`PCO_GAP_FALL_MSB:`PCO_GAP_FALL_LSB];
            gap_q.rise <= pwdata[`PCO_GAP_RISE_MSB:`PCO_GAP_RISE_LSB];
        end
    end

    always_comb begin
        fault_cond[0] = fault_pick(chb_cfg_q);
        fault_cond[1] = fault_pick(chc_cfg_q);
    end

    // input select swaps global overcurrent for the B pin
    // the B pin is one of two dedicated overcurrent inputs of B, next to the B latched input
    always_comb begin
        unique case (chb_cfg_q.overcurrent_source_mode)
            PCO_OVL_GLOBAL_LATCHED: ovl_cond[0] = glob_in.global_latched_overcurrent;
            PCO_OVL_GLOBAL:         ovl_cond[0] = chb_cfg_q.bit8_ovl ? chb_in.overcurrent_pin
                                                                     : glob_in.global_overcurrent;
            PCO_OVL_CHAN_LATCHED:   ovl_cond[0] = chb_in.latched_overcurrent;
            PCO_OVL_CHAN_DIRECT:    ovl_cond[0] = chb_in.overcurrent_pin;
        endcase
    end

    // pin used with polarity in channel mode
    always_comb begin
        unique case (chc_cfg_q.overcurrent_source_mode)
            PCO_OVL_GLOBAL_LATCHED: ovl_cond[1] = glob_in.global_latched_overcurrent;
            PCO_OVL_GLOBAL:         ovl_cond[1] = glob_in.global_overcurrent;
            PCO_OVL_CHAN_LATCHED:   ovl_cond[1] = chc_in.latched_overcurrent;
            PCO_OVL_CHAN_DIRECT:    ovl_cond[1] = chc_in.overcurrent_pin
                                                  ^ chc_cfg_q.bit8_ovl;
        endcase
    end

    // negative output is the complement unless inverted
    // channel C uses the same polarity bits
    always_comb begin
        target[0] = chb_pwm ^ chb_cfg_q.pos_invert;
        target[1] = ~chb_pwm ^ chb_cfg_q.neg_invert;
        target[2] = chc_pwm ^ chc_cfg_q.pos_invert;
        target[3] = ~chc_pwm ^ chc_cfg_q.neg_invert;
    end

    // gap length is count times tick period
    // A pulse shorter than its gap is swallowed: the counter restarts.
    for (genvar i = 0; i < 4; i++) begin : g_gap
        pco_cfg_s         cfg;
        logic             rise_en;
        logic             fall_en;
        logic [CNT_W-1:0] need;

        assign cfg     = (i < 2) ? chb_cfg_q : chc_cfg_q;
        assign rise_en = (i % 2 == 0) ? cfg.pos_rise_gap_en : cfg.neg_rise_gap_en;
        assign fall_en = (i % 2 == 0) ? cfg.pos_fall_gap_en : cfg.neg_fall_gap_en;
        assign need    = target[i] ? gap_need(gap_q.rise, rise_en)
                                   : gap_need(gap_q.fall, fall_en);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                shown_q[i]   <= 1'b0;
                gap_cnt_q[i] <= '0;
            end else if (target[i] == shown_q[i]) begin
                gap_cnt_q[i] <= '0;
            end else if (gap_cnt_q[i] >= need) begin
                shown_q[i]   <= target[i];
                gap_cnt_q[i] <= '0;
            end else begin
                gap_cnt_q[i] <= gap_cnt_q[i] + CNT_W'(1);
            end
        end
    end

    // fault outranks overcurrent unless its field is none
    // forced state bypasses the gap counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q  <= 4'h0;
            enable_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                pco_cfg_s cfg;
                pco_act_e fa;
                pco_act_e oa;
                logic     ch;
                logic [1:0] drv;
                ch  = (i >= 2);
                cfg = ch ? chc_cfg_q : chb_cfg_q;
                fa  = (i % 2 == 0) ? cfg.pos_fault_action : cfg.neg_fault_action;
                oa  = (i % 2 == 0) ? cfg.pos_overcurrent_action
                                   : cfg.neg_overcurrent_action;
                if (fault_cond[ch] && fa != PCO_ACT_NONE) begin
                    drv = act_drive(fa, shown_q[i]);
                end else if (ovl_cond[ch]) begin
                    drv = act_drive(oa, shown_q[i]);
                end else begin
                    drv = {1'b1, shown_q[i]};
                end
                enable_q[i] <= drv[1];
                level_q[i]  <= drv[0];
            end
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign drive_level  = level_q;
    assign drive_enable = enable_q;

endmodule

`default_nettype wire

// >>> sim/pco_chk.sv
/* Assertions on the pco_top ports, bound from the bench top.
   Assumes zero wait state APB and registered drive outputs. */
`timescale 1ns/1ps
`default_nettype none
`include "pco_map.svh"
module pco_chk
    import pco_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire pco_glob_s   glob_in,
    input wire logic [3:0]  drive_level,
    input wire logic [3:0]  drive_enable
);
    pco_cfg_s cfgb_q;
    logic     acc;
    logic     flt;
    // Shadow of channel B config, so forced states can be predicted
    assign acc = psel && penable && pready;
    assign flt = cfgb_q.fault_source_select ? glob_in.direct_fault_halt
                                            : glob_in.latched_fault_halt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfgb_q <= pco_cfg_s'(`PCO_CFG_RESET);
        end else if (acc && pwrite && paddr == `PCO_OFS_CHB_CFG
                     && pwdata[31:24] == `PCO_KEY_VALUE) begin
            cfgb_q <= pco_cfg_s'(pwdata[18:0]);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    chk_unmapped_err: assert property
        (psel && !penable && paddr > `PCO_OFS_STATUS |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_key_read_back: assert property
        (acc && !pwrite && paddr == `PCO_OFS_CHB_CFG
         |-> prdata == {13'h0, cfgb_q[18:16], 1'b0, cfgb_q[14:0]})
        else $error("config read back wrong");
    chk_pos_fault_hiz: assert property
        (flt && cfgb_q.pos_fault_action == PCO_ACT_HIZ |=> !drive_enable[0])
        else $error("pos leg not released");
    chk_neg_fault_hiz: assert property
        (flt && cfgb_q.neg_fault_action == PCO_ACT_HIZ |=> !drive_enable[1])
        else $error("neg leg not released");
    chk_pos_fault_drive: assert property
        (flt && cfgb_q.pos_fault_action inside {PCO_ACT_LOW, PCO_ACT_HIGH}
         |=> drive_enable[0] && drive_level[0] == $past(cfgb_q.pos_fault_action[1]))
        else $error("pos leg not forced");
    chk_neg_fault_drive: assert property
        (flt && cfgb_q.neg_fault_action inside {PCO_ACT_LOW, PCO_ACT_HIGH}
         |=> drive_enable[1] && drive_level[1] == $past(cfgb_q.neg_fault_action[1]))
        else $error("neg leg not forced");
    cover property (flt && cfgb_q.pos_fault_action == PCO_ACT_HIGH);
    cover property (acc && pwrite && pwdata[31:24] != `PCO_KEY_VALUE);
    cover property (pslverr);
endmodule
`default_nettype wire

// >>> sim/pco_leg_model.sv
/* Model of the external upper and lower driver legs: resolves pads.
   Assumes pad levels are only meaningful while enabled. */
`timescale 1ns/1ps
`default_nettype none
module pco_leg_model (
    input  wire logic       pclk,
    input  wire logic [3:0] drive_level,
    input  wire logic [3:0] drive_enable,
    output var  logic [3:0] pad
);
    logic [3:0] last_q;
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            if (drive_enable[i]) begin
                last_q[i] <= drive_level[i];
            end
        end
    end
    // A released leg floats; show the opposite so stale levels never pass
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad[i] = drive_enable[i] ? drive_level[i] : ~last_q[i];
        end
    end
endmodule
`default_nettype wire

// >>> sim/pco_top_tb_top.sv
/* Bench top for pco_top: APB traffic, fault and overcurrent stimulus,
   status reads compared against a queue. Needs checker and leg model. */
`timescale 1ns/1ps
`default_nettype none
`include "pco_map.svh"
`define CMP(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pco_top_tb_top
    import pco_pkg::*;
;
    localparam int TICK = 2;
    localparam int RISE = 2;
    localparam int FALL = 3;
    localparam logic [7:0] CHB = `PCO_OFS_CHB_CFG;
    localparam logic [7:0] CHC = `PCO_OFS_CHC_CFG;
    typedef struct packed {
        logic [31:0] v;
        logic [31:0] m;
    } pco_exp_s;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, chb_pwm, chc_pwm;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata;
    logic [3:0]   drive_level, drive_enable, pad;
    pco_glob_s    glob_in;
    pco_chan_in_s chb_in, chc_in;
    pco_exp_s     exp_q[$];
    pco_exp_s     e;
    int           n_errors, samples_checked;
    pco_top #(.GAP_TICK_CYCLES(TICK)) u_pco_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chb_pwm(chb_pwm), .chc_pwm(chc_pwm),
        .glob_in(glob_in), .chb_in(chb_in), .chc_in(chc_in), .drive_level(drive_level),
        .drive_enable(drive_enable));
    pco_leg_model u_pco_leg_model (.pclk(pclk), .drive_level(drive_level),
        .drive_enable(drive_enable), .pad(pad));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back('{v, m});
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic wcfg(input logic [7:0] a, input logic [18:0] c);
        xfer(1'b1, a, {`PCO_KEY_VALUE, 5'h00, c});
    endtask
    // Each leg as {enable, level}; a hidden level is masked out
    function automatic logic [1:0] leg(input logic [1:0] act, input logic nrm);
        return (act == 2'h3) ? {1'b1, nrm} : {act != 2'h0, act == 2'h2};
    endfunction
    task automatic st4(input logic [1:0] bp, bn, cp, cn);
        rd(`PCO_OFS_STATUS, {24'h0, cn[1], cp[1], bn[1], bp[1], cn[0], cp[0], bn[0], bp[0]},
           {24'h0, 4'hF, cn[1], cp[1], bn[1], bp[1]});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CMP("prdata", e.v, prdata & e.m)
        end
    end
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("timeout");
        end_sim();
    end
    initial begin
        logic [18:0] c;
        logic [7:0]  a;
        logic [1:0]  q;
        logic        f;
        logic        fh;
        {presetn, psel, penable, pwrite, chb_pwm, chc_pwm} = '0;
        {paddr, pwdata, glob_in, chb_in, chc_in} = '0;
        n_errors = 0;
        samples_checked = 0;
        void'($urandom(77833));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CHB, 32'h0, '1);
        rd(CHC, 32'h0, '1);
        rd(`PCO_OFS_GAP_TIME, 32'h0, '1);
        rd(8'h10, 32'h0, '1);
        st4(2'b10, 2'b11, 2'b10, 2'b11);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            c = 19'($urandom);
            a = i[0] ? CHC : CHB;
            wcfg(a, c);
            rd(a, {13'h0, c[18:16], 1'b0, c[14:0]}, '1);
            xfer(1'b1, a, {`PCO_KEY_VALUE ^ 8'(1 + $urandom % 255), 5'h0, ~c});
            rd(a, {13'h0, c[18:16], 1'b0, c[14:0]}, '1);
        end
        $display("test key done");
        for (int p = 0; p < 8; p++) begin
            wcfg(CHB, {4'h0, p[0], p[1], 5'h00, 8'hFF});
            wcfg(CHC, {4'h0, p[0], p[1], 5'h00, 8'hFF});
            chb_pwm <= p[2];
            chc_pwm <= !p[2];
            repeat (3) @(posedge pclk);
            st4({1'b1, p[2] ^ p[0]}, {1'b1, !p[2] ^ p[1]}, {1'b1, !p[2] ^ p[0]},
                {1'b1, p[2] ^ p[1]});
        end
        $display("test polarity done");
        glob_in <= 4'b0110;
        chb_pwm <= 1'b1;
        chc_pwm <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            q = 2'(i);
            wcfg(CHB, {1'b1, 10'h000, q, ~q, 4'h6});
            wcfg(CHC, {1'b0, 10'h000, q, ~q, 4'h6});
            st4(q == 2'h3 ? 2'b10 : leg(q, 1'b1), q == 2'h0 ? 2'b11 : leg(~q, 1'b0),
                2'b10, 2'b11);
        end
        $display("test fault done");
        chc_pwm <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            q = 2'(i);
            glob_in <= {2'b00, i[3:2] == 2'd0, i[3:2] == 2'd1};
            chb_in <= {i[3:2] == 2'd2, i[3:2] == 2'd3};
            chc_in <= {i[3:2] == 2'd2, i[3:2] == 2'd3};
            wcfg(CHB, {1'b1, q, 8'h00, 8'hF6});
            wcfg(CHC, {1'b1, q, 8'h00, 8'hF6});
            f = (q == i[3:2]);
            st4({1'b1, !f}, {1'b1, f}, {1'b1, !f}, {1'b1, f});
        end
        for (int j = 0; j < 2; j++) begin
            glob_in <= 4'b0001;
            chb_in <= {1'b0, j == 0};
            chc_in <= {1'b0, j == 0};
            wcfg(CHB, {1'b1, 2'h1, 7'h00, 1'b1, 8'hF6});
            wcfg(CHC, {1'b1, 2'h3, 7'h00, 1'b1, 8'hF6});
            f = (j == 0);
            st4({1'b1, !f}, {1'b1, f}, {1'b1, f}, {1'b1, !f});
        end
        $display("test overcurrent done");
        {glob_in, chb_in, chc_in, chb_pwm, chc_pwm} <= 10'h001;
        xfer(1'b1, `PCO_OFS_GAP_TIME, {16'h0, 8'(FALL), 8'(RISE)});
        rd(`PCO_OFS_GAP_TIME, {16'h0, 8'(FALL), 8'(RISE)}, '1);
        wcfg(CHB, 19'h00CFF);
        // Channel C times the other two enables, on a falling PWM edge
        wcfg(CHC, 19'h012FF);
        for (int k = 4; k < 8; k++) begin
            repeat (20) @(posedge pclk);
            chb_pwm <= 1'b1;
            chc_pwm <= 1'b0;
            repeat (k) @(posedge pclk);
            f  = (k + 1 >= RISE * TICK + 2);
            fh = (k + 1 < FALL * TICK + 2);
            st4({1'b1, f}, {1'b1, fh}, {1'b1, fh}, {1'b1, f});
            chb_pwm <= 1'b0;
            chc_pwm <= 1'b1;
        end
        repeat (20) @(posedge pclk);
        `CMP("pad", 4'h6, pad)
        $display("test gap done");
        end_sim();
    end
endmodule
bind pco_top pco_chk u_pco_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .glob_in(glob_in), .drive_level(drive_level),
    .drive_enable(drive_enable));
`default_nettype wire
